// ==== inc/phase_zero_pkg.sv ====
// Constants shared by the phase-zero commutation initialisation block.
package phase_zero_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam logic [7:0]  OFS_CMD     = 8'h00;
    localparam logic [7:0]  OFS_HOLD    = 8'h04;
    localparam logic [7:0]  OFS_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_DIST    = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_ST  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MSK = 8'h14;
    localparam logic [7:0]  OFS_VOLT    = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CMD_METHOD_LSB = 16;
    localparam int          ST_BUSY        = 0;
    localparam int          ST_INIT        = 1;
    localparam int          ST_TWO_PHASE   = 2;
    localparam int          ST_ERR_LSB     = 8;
    localparam int          IRQ_DONE       = 0;
    localparam int          IRQ_FAIL       = 1;
    localparam int          IRQ_REJECT     = 2;
    localparam int          IRQ_W          = 3;

    // ------------------------------------------------------------
    // Methods, voltage and hold limits, error codes
    // ------------------------------------------------------------
    localparam logic [1:0]  METHOD_PHASE_ZERO = 2'h0;
    // Drive code is volts * 65536 / 20; 4.998 V gives 16377 codes.
    localparam logic signed [15:0] VOLT_MAX   = 16'sh3ff9;
    localparam logic signed [15:0] VOLT_MIN   = -16'sh3ff9;
    localparam logic signed [15:0] VOLT_RST   = 16'sh0000;
    localparam logic [15:0] HOLD_MIN          = 16'h0064;
    localparam logic [15:0] HOLD_MAX          = 16'h7fff;
    localparam logic [14:0] HOLD_RST          = 15'h03e8;
    localparam logic [7:0]  ERR_NONE          = 8'h00;
    localparam logic [7:0]  ERR_NO_MOTION     = 8'h71;
    localparam logic [7:0]  ERR_TIMEOUT       = 8'h72;
    localparam logic [31:0] MOTION_MIN_COUNTS = 32'h0000_0001;
    localparam logic [14:0] SETTLE_SAMPLES    = 15'h0008;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DRIVE  = 2'b01,
        ST_ZERO   = 2'b11,
        ST_FINISH = 2'b10
    } seq_state_t;

endpackage : phase_zero_pkg

// ==== verification/motor_model.sv ====
// Behavioural motor, encoder and sine amplifier at the far side of the sequencer.
`timescale 1ns/1ps
module motor_model
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // Drive in, feedback out
    input  wire logic        i_drive_en,
    input  wire logic [1:0]  i_mode,
    output logic      [31:0] o_position,
    output logic             o_sample_tick
);
    logic [1:0] div_ff;
    logic [7:0] moves_ff;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            div_ff <= 2'h0;
        else
            div_ff <= div_ff + 2'h1;
    end

    assign o_sample_tick = (div_ff == 2'h3);

    // voltage too small
    // Mode 0 never moves, mode 1 moves for 20 ticks then rests, mode 2 hunts.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_position <= 32'h0000_0000;
            moves_ff   <= 8'h00;
        end
        else if (!i_drive_en)
            moves_ff <= 8'h00;
        else if (o_sample_tick && i_mode != 2'h0)
        begin
            if (i_mode == 2'h2 || moves_ff < 8'h14)
                o_position <= o_position + 32'h0000_0003;
            moves_ff <= moves_ff + 8'h01;
        end
    end
endmodule : motor_model

// ==== verification/testbench.sv ====
// Self-checking bench for the phase-zero initialisation sequencer.
`timescale 1ns/1ps
module testbench;
    import phase_zero_pkg::*;
    logic        i_clock, i_sys_rst, i_psel, i_penable, i_pwrite, i_two_phase_option;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, i_position, rd;
    logic [15:0] o_drive_voltage;
    logic        o_pready, o_pslverr, i_sample_tick, o_drive_en, o_phase_clear, o_busy;
    logic        o_servo_enable_cmd, o_motor_off_cmd, o_other_method_req, o_irq, err;
    logic [1:0]  mode;
    int          miscompares, tests_run, n_en, n_off, n_clr, n_oth, n_tk;

    phase_zero_init DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_sample_tick(i_sample_tick), .i_position(i_position),
        .i_two_phase_option(i_two_phase_option), .o_drive_en(o_drive_en),
        .o_drive_voltage(o_drive_voltage), .o_phase_clear(o_phase_clear),
        .o_servo_enable_cmd(o_servo_enable_cmd), .o_motor_off_cmd(o_motor_off_cmd),
        .o_other_method_req(o_other_method_req), .o_busy(o_busy), .o_irq(o_irq));
    motor_model partner (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_drive_en(o_drive_en),
        .i_mode(mode), .o_position(i_position), .o_sample_tick(i_sample_tick));

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    always @(posedge i_clock)
    begin
        n_en  += (o_servo_enable_cmd === 1'b1);
        n_off += (o_motor_off_cmd === 1'b1);
        n_clr += (o_phase_clear === 1'b1);
        n_oth += (o_other_method_req === 1'b1);
        n_tk  += (o_drive_en === 1'b1 && i_sample_tick === 1'b1);
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        // Ready and data are taken mid-cycle, settled, and stand until the sampling edge.
        do
            @(negedge i_clock);
        while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        @(posedge i_clock);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task run_cmd(input logic [31:0] v);
        n_en = 0; n_off = 0; n_clr = 0; n_tk = 0;
        apb(1'b1, OFS_CMD, v);
        @(posedge i_clock);
        chk("drive_en", 32'h1, {31'h0, o_drive_en});
        chk("voltage", {16'h0, (v[15] ? 16'hc007 : 16'h3ff9)}, {16'h0, o_drive_voltage});
        while (o_busy === 1'b1)
            @(posedge i_clock);
        repeat (4) @(posedge i_clock);
        chk("ticks", 32'd100, n_tk);
    endtask : run_cmd

    task t_reset;
        apb(1'b0, OFS_HOLD, 32'h0);
        chk("hold", 32'h3e8, rd);
        apb(1'b0, OFS_VOLT, 32'h0);
        chk("volt", 32'h0, rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b1, OFS_HOLD, 32'd50);
        apb(1'b0, OFS_HOLD, 32'h0);
        chk("hold clamp", 32'h64, rd);
        $display("test reset done");
    endtask : t_reset

    task t_fail(input logic [1:0] m, input logic [31:0] v, input logic [7:0] code);
        mode <= m;
        apb(1'b1, OFS_IRQ_MSK, 32'h1);
        run_cmd(v);
        chk("ends", 32'h0001_0000, {n_off[15:0], n_en[7:0], n_clr[7:0]});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("error", {24'h0, code}, {24'h0, rd[15:8]});
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk("irq status", 32'h2, rd);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        apb(1'b1, OFS_IRQ_ST, 32'h7);
        $display("test fail done");
    endtask : t_fail

    task t_success;
        mode <= 2'h1;
        apb(1'b1, OFS_IRQ_MSK, 32'h7);
        fork
            run_cmd(32'h0000_8000);
            begin
                repeat (20) @(posedge i_clock);
                apb(1'b1, OFS_CMD, 32'h0000_0010);
            end
        join
        chk("ends", 32'h10001, {n_off[7:0], n_en[7:0], n_clr[15:0]});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        apb(1'b0, OFS_DIST, 32'h0);
        chk("distance", 32'h0, rd);
        apb(1'b0, OFS_VOLT, 32'h0);
        chk("volt", 32'hffffc007, rd);
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk("irq status", 32'h5, rd);
        chk("irq", 32'h1, {31'h0, o_irq});
        apb(1'b1, OFS_IRQ_ST, 32'h7);
        // The status clears at the write edge and the output flop follows one edge later.
        repeat (2) @(posedge i_clock);
        chk("irq clear", 32'h0, {31'h0, o_irq});
        $display("test success done");
    endtask : t_success

    task t_method;
        n_oth = 0;
        apb(1'b1, OFS_CMD, 32'h0001_0000);
        i_two_phase_option <= 1'b1;
        repeat (5) @(posedge i_clock);
        apb(1'b1, OFS_CMD, 32'h0002_0000);
        repeat (2) @(posedge i_clock);
        chk("other req", 32'h1, n_oth);
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        chk("reject", 32'h4, rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("two phase", 32'h1, {31'h0, rd[2]});
        $display("test method done");
    endtask : t_method

    task summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (20000) @(posedge i_clock);
        miscompares++;
        summarize();
    end

    initial
    begin
        i_sys_rst = 1'b1; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
        i_paddr = 8'h00; i_pwdata = 32'h0; i_two_phase_option = 1'b0; mode = 2'h0;
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_reset();
        t_fail(2'h0, 32'h0000_7fff, ERR_NO_MOTION);
        t_success();
        t_fail(2'h2, 32'h0000_7fff, ERR_TIMEOUT);
        t_method();
        summarize();
    end
endmodule : testbench

// ==== verilog/level_sync.sv ====
// Two-stage synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
module level_sync
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    // Level in and out
    input  wire logic i_level,
    output logic      o_level
);

    logic meta_ff;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            meta_ff <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            meta_ff <= i_level;
            o_level <= meta_ff;
        end
    end

endmodule : level_sync

// ==== verilog/phase_zero_init.sv ====
// Phase-zero commutation initialisation sequencer with APB registers.
// Behaviour
// - On request drive motor to zero magnetic phase, then zero the phase.
// - Drive voltage is signed, clamped to +-4.998 V, 20/65536 V steps.
// - Negative voltage without error ends with servo enabled, positive or any error ends motor off.
// - Hold torque for 100 to 32767 samples, default 1000.
// - A readable distance gives counts from present position to zero.
// - A request is accepted while the motor is off.
// - Error 113 when the voltage produced no motion.
// - Error 114 when the run did not settle within the hold count.
// - With the two-phase option, only phase-zero initialisation is allowed.
`timescale 1ns/1ps
module phase_zero_init
(
    // Clock and reset
    input  wire logic                               i_clock,
    input  wire logic                               i_sys_rst,
    // APB slave
    input  wire logic                               i_psel,
    input  wire logic                               i_penable,
    input  wire logic                               i_pwrite,
    input  wire logic [phase_zero_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [phase_zero_pkg::DATA_W-1:0]  i_pwdata,
    output logic      [phase_zero_pkg::DATA_W-1:0]  o_prdata,
    output logic                                    o_pready,
    output logic                                    o_pslverr,
    // Servo side
    input  wire logic                               i_sample_tick,
    input  wire logic [31:0]                        i_position,
    input  wire logic                               i_two_phase_option,
    output logic                                    o_drive_en,
    output logic      [15:0]                        o_drive_voltage,
    output logic                                    o_phase_clear,
    output logic                                    o_servo_enable_cmd,
    output logic                                    o_motor_off_cmd,
    output logic                                    o_other_method_req,
    output logic                                    o_busy,
    output logic                                    o_irq
);
    import phase_zero_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    seq_state_t          state_ff;
    logic signed [15:0]  volt_ff;
    logic [14:0]         hold_ff;
    logic [14:0]         hold_cnt;
    logic [14:0]         settle_cnt;
    logic [31:0]         start_pos_ff;
    logic [31:0]         prev_pos_ff;
    logic [31:0]         zero_pos_ff;
    logic [31:0]         distance_ff;
    logic [31:0]         move;
    logic [7:0]          err_ff;
    logic                moved_ff;
    logic                init_ff;
    logic                two_phase;
    logic [IRQ_W-1:0]    irq_st_ff;
    logic [IRQ_W-1:0]    irq_msk_ff;
    logic [IRQ_W-1:0]    irq_set;
    logic                wr_en;
    logic                setup;
    logic                cmd_wr;
    logic [1:0]          method;
    logic                launch;
    logic                reject;
    logic                end_now;
    logic                settled;
    logic                still;
    logic signed [15:0]  wr_volt;
    logic [15:0]         wr_hold;

    level_sync u_two_phase_sync
    (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_level   (i_two_phase_option),
        .o_level   (two_phase)
    );

    // ------------------------------------------------------------
    // APB access
    // ------------------------------------------------------------
    assign setup  = i_psel && !i_penable;
    assign wr_en  = i_psel && i_penable && i_pwrite && o_pready;
    assign cmd_wr = wr_en && (i_paddr == OFS_CMD);
    assign method = i_pwdata[CMD_METHOD_LSB +: 2];
    assign wr_volt = i_pwdata[15:0];
    assign wr_hold = i_pwdata[15:0];

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
        end
        else
        begin
            o_pready  <= setup;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
            if (setup)
            begin
                unique case (i_paddr)
                    OFS_CMD:     o_prdata <= {30'h0, state_ff};
                    OFS_HOLD:    o_prdata <= {17'h0, hold_ff};
                    OFS_STATUS:  o_prdata <= {16'h0, err_ff, 5'h0, two_phase,
                                              init_ff, o_busy};
                    OFS_DIST:    o_prdata <= distance_ff;
                    OFS_IRQ_ST:  o_prdata <= {29'h0, irq_st_ff};
                    OFS_IRQ_MSK: o_prdata <= {29'h0, irq_msk_ff};
                    OFS_VOLT:    o_prdata <= {{16{volt_ff[15]}}, volt_ff};
                    default:     o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            volt_ff <= VOLT_RST;
        else if (launch)
            volt_ff <= (wr_volt > VOLT_MAX) ? VOLT_MAX :
                       (wr_volt < VOLT_MIN) ? VOLT_MIN : wr_volt;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            hold_ff <= HOLD_RST;
        else if (wr_en && (i_paddr == OFS_HOLD))
            hold_ff <= (wr_hold < HOLD_MIN) ? HOLD_MIN[14:0] :
                       (wr_hold > HOLD_MAX) ? HOLD_MAX[14:0] : wr_hold[14:0];
    end

    // ------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------
    // motor-off accepted
    // A request is taken in any motor state; only a running sequence blocks it.
    // busy refuses requests
    assign launch = cmd_wr && (method == METHOD_PHASE_ZERO) && (state_ff == ST_IDLE);
    assign reject = cmd_wr && (((method == METHOD_PHASE_ZERO) && (state_ff != ST_IDLE))
                    || ((method != METHOD_PHASE_ZERO) && two_phase));

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            o_other_method_req <= 1'b0;
        else
            o_other_method_req <= cmd_wr && (method != METHOD_PHASE_ZERO) && !two_phase;
    end

    // ------------------------------------------------------------
    // Sample counting
    // ------------------------------------------------------------
    assign still   = (i_position == prev_pos_ff);
    assign settled = (settle_cnt >= SETTLE_SAMPLES);
    assign end_now = (state_ff == ST_DRIVE) && i_sample_tick
                     && (hold_cnt >= (hold_ff - 15'h0001));
    assign move    = i_position - start_pos_ff;

    tick_counter #(.WIDTH(15)) u_hold_cnt
    (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_clear   (state_ff != ST_DRIVE),
        .i_tick    (i_sample_tick),
        .o_count   (hold_cnt)
    );

    tick_counter #(.WIDTH(15)) u_settle_cnt
    (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_clear   ((state_ff != ST_DRIVE) || (i_sample_tick && !still)),
        .i_tick    (i_sample_tick),
        .o_count   (settle_cnt)
    );

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            prev_pos_ff <= '0;
        else if (i_sample_tick || launch)
            prev_pos_ff <= i_position;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            start_pos_ff <= '0;
        else if (launch)
            start_pos_ff <= i_position;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || launch)
            moved_ff <= 1'b0;
        else if ((state_ff == ST_DRIVE) && !move[31] && (move >= MOTION_MIN_COUNTS))
            moved_ff <= 1'b1;
        else if ((state_ff == ST_DRIVE) && move[31] && ((-move) >= MOTION_MIN_COUNTS))
            moved_ff <= 1'b1;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            state_ff <= ST_IDLE;
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (launch)
                        state_ff <= ST_DRIVE;
                ST_DRIVE:
                    if (end_now)
                        state_ff <= (moved_ff && settled) ? ST_ZERO : ST_FINISH;
                ST_ZERO:
                    state_ff <= ST_FINISH;
                ST_FINISH:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || launch)
            err_ff <= ERR_NONE;
        else if (end_now && !moved_ff)
            err_ff <= ERR_NO_MOTION;
        else if (end_now && !settled)
            err_ff <= ERR_TIMEOUT;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            o_busy <= 1'b0;
        else
            o_busy <= (state_ff == ST_IDLE) ? launch : (state_ff != ST_FINISH);
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_drive_en      <= 1'b0;
            o_drive_voltage <= '0;
        end
        else if (launch)
        begin
            o_drive_en      <= 1'b1;
            o_drive_voltage <= (wr_volt > VOLT_MAX) ? VOLT_MAX :
                               (wr_volt < VOLT_MIN) ? VOLT_MIN : wr_volt;
        end
        else if (end_now)
        begin
            o_drive_en      <= 1'b0;
            o_drive_voltage <= '0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            zero_pos_ff   <= '0;
            init_ff       <= 1'b0;
            o_phase_clear <= 1'b0;
        end
        else
        begin
            o_phase_clear <= (state_ff == ST_ZERO);
            if (state_ff == ST_ZERO)
            begin
                zero_pos_ff <= i_position;
                init_ff     <= 1'b1;
            end
            else if (launch)
                init_ff     <= 1'b0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            distance_ff <= '0;
        else
            distance_ff <= i_position - zero_pos_ff;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_servo_enable_cmd <= 1'b0;
            o_motor_off_cmd    <= 1'b0;
        end
        else
        begin
            o_servo_enable_cmd <= (state_ff == ST_FINISH) && (err_ff == ERR_NONE)
                                  && volt_ff[15];
            o_motor_off_cmd    <= (state_ff == ST_FINISH)
                                  && ((err_ff != ERR_NONE) || !volt_ff[15]);
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_set[IRQ_DONE]   = (state_ff == ST_FINISH) && (err_ff == ERR_NONE);
    assign irq_set[IRQ_FAIL]   = (state_ff == ST_FINISH) && (err_ff != ERR_NONE);
    assign irq_set[IRQ_REJECT] = reject;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            irq_st_ff <= '0;
        else if (wr_en && (i_paddr == OFS_IRQ_ST))
            irq_st_ff <= (irq_st_ff & ~i_pwdata[IRQ_W-1:0]) | irq_set;
        else
            irq_st_ff <= irq_st_ff | irq_set;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            irq_msk_ff <= '0;
        else if (wr_en && (i_paddr == OFS_IRQ_MSK))
            irq_msk_ff <= i_pwdata[IRQ_W-1:0];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_st_ff & irq_msk_ff);
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_zero_phase_pulse: assert property ((state_ff == ST_ZERO) |=> o_phase_clear
        && (zero_pos_ff == $past(i_position)) && (state_ff == ST_FINISH))
        else $error("phase not zeroed after drive");
    a_volt_in_range: assert property ($signed(o_drive_voltage) <= VOLT_MAX
        && $signed(o_drive_voltage) >= VOLT_MIN)
        else $error("drive voltage out of range");
    a_sign_final: assert property ((state_ff == ST_FINISH) && (err_ff == ERR_NONE)
        |=> (o_servo_enable_cmd == volt_ff[15]) && (o_motor_off_cmd != volt_ff[15]))
        else $error("final state does not follow voltage sign");
    a_hold_range: assert property ((hold_ff >= HOLD_MIN[14:0]) && (hold_ff <= HOLD_MAX[14:0]))
        else $error("hold count out of range");
    a_dist_track: assert property (##1 distance_ff == $past(i_position) - $past(zero_pos_ff))
        else $error("distance does not track position");
    a_accept_idle: assert property (cmd_wr && (method == METHOD_PHASE_ZERO)
        && (state_ff == ST_IDLE) |=> (state_ff == ST_DRIVE) && o_drive_en)
        else $error("request not accepted");
    a_err_no_motion: assert property (end_now && !moved_ff
        |=> (err_ff == ERR_NO_MOTION) ##1 o_motor_off_cmd)
        else $error("missing no-motion error");
    a_err_timeout: assert property (end_now && moved_ff && !settled
        |=> (err_ff == ERR_TIMEOUT) && (state_ff == ST_FINISH))
        else $error("missing timeout error");
    a_two_phase_lock: assert property (cmd_wr && (method != METHOD_PHASE_ZERO) && two_phase
        |=> !o_other_method_req ##1 irq_st_ff[IRQ_REJECT])
        else $error("other method not refused");
    a_tick_hold: assert property ((state_ff == ST_DRIVE) && !end_now
        |=> (state_ff == ST_DRIVE))
        else $error("drive left before hold count");
    a_busy_refuse: assert property ((state_ff != ST_IDLE) |-> o_busy && !launch)
        else $error("busy flag or refusal wrong");

    c_success: cover property ((state_ff == ST_ZERO) ##2 o_servo_enable_cmd);
    c_no_motion: cover property (end_now && !moved_ff);
    c_timeout: cover property (end_now && moved_ff && !settled);
    c_rejected: cover property (reject ##2 o_irq);

endmodule : phase_zero_init

// ==== verilog/tick_counter.sv ====
// Saturating counter of servo sample ticks with a clear that wins.
`timescale 1ns/1ps
module tick_counter
#(
    parameter int WIDTH = 15
)
(
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    // Control
    input  wire logic             i_clear,
    input  wire logic             i_tick,
    // Count
    output logic [WIDTH-1:0]      o_count
);

    // A one-bit counter cannot both count and saturate.
    if (WIDTH < 2)
    begin : g_width_check
        $error("tick_counter width too small");
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || i_clear)
            o_count <= '0;
        else if (i_tick && (o_count != {WIDTH{1'b1}}))
            o_count <= o_count + 1'b1;
    end

endmodule : tick_counter
